//--- core/pmc_power_mode_control.sv
// power mode controller: mode selection, wake-up, brownout, flags, serial options
// Operation
// - both select bits one enters total power-down
// - total power-down disables comparators and brownout
// - no brownout reset or interrupt there
// - comparator and brownout never wake total power-down
// - RC oscillator off unless sysclock and RTC
// - watchdog wakes when its clock select set
// - level external irqs and keypad wake
// - RTC wakes, keeps crystal if RTC uses it, unless RTC powered down
// - mode select lives in bits 0 and 1
// - bits 2 and 3 are free flags
// - bit 4 picks brownout interrupt or reset
// - bit 5 powers down brownout detection
// - flash commands aborted while bit 5 set
// - bit 6 selects serial bit 7 meaning
// - bit 7 passes or halves timer overflow
// - 00 normal, 01 idle, 10 power-down
// - interrupt wake needs enable and global enable
// - wake waits 1024 or 256 clocks
`timescale 1ns/100ps
module pmc_power_mode_control
   import pmc_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        brownoutPin,
   input  wire logic        extIrqZeroPin,
   input  wire logic        extIrqOnePin,
   input  wire logic        keypadIrq,
   input  wire logic        comparatorIrq,
   input  wire logic        rtcIrq,
   input  wire logic        wdtIrq,
   input  wire logic        wdtReset,
   input  wire logic        timer1Overflow,
   input  wire logic        flashCmdReq,
   input  wire logic        uartModeBit,
   input  wire logic        uartFramingError,
   output logic             cpuHalt,
   output logic             oscEnable,
   output logic             rcOscEnable,
   output logic             xtalOscEnable,
   output logic             brownoutEnable,
   output logic             comparatorEnable,
   output logic             brownoutReset,
   output logic             flashCmdGo,
   output logic             flashCmdAbort,
   output logic             uartBaudTick,
   output logic             serialBit7View,
   output logic             serialBit7IsFrameErr,
   output logic             irq
);

   pmc_power_t  pwr_reg;
   pmc_cfg_t    cfg_reg;
   pmc_wen_t    wen_reg;
   logic [2:0]  status_reg;
   logic [2:0]  status_next;
   logic [2:0]  mask_reg;
   pmc_state_t  state_reg;
   pmc_state_t  state_next;
   logic [10:0] count_reg;
   logic [2:0]  pinMeta_reg;
   logic [2:0]  pinSync_reg;
   logic        pinPrev_reg;
   logic        halfBaud_reg;
   logic        setupPhase;
   logic        accessWrite;
   logic        hit;
   logic        pwrWrite;
   logic        bodSync;
   logic        extZero;
   logic        extOne;
   logic        bodEvent;
   logic        rtcActive;
   logic        wdtWake;
   logic        commonWake;
   logic        pdOnlyWake;
   logic        idleExit;
   logic        bodResetReq;
   logic        lowPowerNext;
   logic        rcKeep;
   logic [7:0]  pwrWdata;

   // address decode shared by the read and write paths
   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == PMC_ADDR_PWR) || (a == PMC_ADDR_CFG) || (a == PMC_ADDR_WEN)
            || (a == PMC_ADDR_STAT) || (a == PMC_ADDR_MASK) || (a == PMC_ADDR_STATE);
   endfunction

   assign setupPhase  = psel && !penable;
   assign accessWrite = psel && penable && pwrite;
   assign hit         = mapped(paddr);
   assign pwrWrite    = accessWrite && (paddr == PMC_ADDR_PWR);
   assign pwrWdata    = pwdata[7:0];

   // pin synchroniser; edges are taken from the second stage onward only
   always_ff @(posedge mclk) begin
      if (rst) begin
         pinMeta_reg <= 3'h0;
         pinSync_reg <= 3'h0;
         pinPrev_reg <= 1'b0;
      end else begin
         pinMeta_reg <= {brownoutPin, extIrqOnePin, extIrqZeroPin};
         pinSync_reg <= pinMeta_reg;
         pinPrev_reg <= pinSync_reg[2];
      end
   end

   assign bodSync = pinSync_reg[2];
   assign extOne  = pinSync_reg[1];
   assign extZero = pinSync_reg[0];

   // a brownout only counts while the detector is powered
   assign bodEvent    = bodSync && !pinPrev_reg && brownoutEnable;
   assign bodResetReq = bodEvent && !pwr_reg.brownoutIrqSelect;

   // wake qualification; interrupts need their enable plus the global one
   assign rtcActive  = cfg_reg.rtcEnable && !cfg_reg.rtcPowerdown;
   assign wdtWake    = cfg_reg.watchdogClockSelect
                    && ((wdtIrq && wen_reg.wdtEn && wen_reg.globalIrqEnable)
                    || (wdtReset && cfg_reg.wdtResetEnable));
   assign commonWake = wdtWake
                    || (wen_reg.globalIrqEnable && (
                          (extZero && cfg_reg.extIrqZeroLevel && wen_reg.extZeroEn)
                       || (extOne && cfg_reg.extIrqOneLevel && wen_reg.extOneEn)
                       || (keypadIrq && wen_reg.keypadEn)
                       || (rtcIrq && rtcActive && wen_reg.rtcEn)));
   // comparator and brownout interrupts are heard in idle and plain power-down, not in total power-down
   assign pdOnlyWake = bodResetReq
                    || (wen_reg.globalIrqEnable
                       && ((comparatorIrq && wen_reg.compEn)
                       || (bodEvent && pwr_reg.brownoutIrqSelect && wen_reg.bodEn)));
   // idle keeps every peripheral alive, so edge-mode externals count too
   assign idleExit   = commonWake || pdOnlyWake
                    || (wen_reg.globalIrqEnable
                       && ((extZero && wen_reg.extZeroEn) || (extOne && wen_reg.extOneEn)));

   // power mode sequencer
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         PMC_RUN: begin
            if (pwrWrite) begin
               unique case (pwrWdata[1:0])
                  PMC_MODE_IDLE:  state_next = PMC_IDLE;
                  PMC_MODE_PDOWN: state_next = PMC_PDOWN;
                  PMC_MODE_TOTAL: state_next = PMC_TOTAL;
                  PMC_MODE_NORMAL: state_next = PMC_RUN;
               endcase
            end
         end
         PMC_IDLE: begin
            if (idleExit) begin
               state_next = PMC_RUN;
            end
         end
         PMC_PDOWN: begin
            if (commonWake || pdOnlyWake) begin
               state_next = PMC_WAKE;
            end
         end
         PMC_TOTAL: begin
            if (commonWake) begin
               state_next = PMC_WAKE;
            end
         end
         PMC_WAKE: begin
            if (count_reg == 11'h000) begin
               state_next = PMC_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= PMC_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   // oscillator stability count; the state lasts exactly the start-up count
   always_ff @(posedge mclk) begin
      if (rst) begin
         count_reg <= 11'h000;
      end else if (state_next == PMC_WAKE && state_reg != PMC_WAKE) begin
         count_reg <= (cfg_reg.xtalClock ? PMC_XTAL_STARTUP : PMC_RC_STARTUP)
                    - 11'h001;
      end else if (state_reg == PMC_WAKE && count_reg != 11'h000) begin
         count_reg <= count_reg - 11'h001;
      end
   end

   // power control register; mode bits drop back to normal on any exit
   always_ff @(posedge mclk) begin
      if (rst) begin
         pwr_reg <= pmc_power_t'(PMC_PWR_RESET);
      end else if (pwrWrite) begin
         pwr_reg <= pmc_power_t'(pwrWdata);
      end else if (state_reg != PMC_RUN && state_next == PMC_RUN) begin
         pwr_reg.powerModeSel <= PMC_MODE_NORMAL;
      end
   end

   // configuration, wake enables and interrupt mask
   always_ff @(posedge mclk) begin
      if (rst) begin
         cfg_reg  <= pmc_cfg_t'(PMC_CFG_RESET);
         wen_reg  <= pmc_wen_t'(PMC_WEN_RESET);
         mask_reg <= PMC_ST_RESET;
      end else if (accessWrite) begin
         if (paddr == PMC_ADDR_CFG) begin
            cfg_reg <= pmc_cfg_t'(pwdata[9:0]);
         end
         if (paddr == PMC_ADDR_WEN) begin
            wen_reg <= pmc_wen_t'(pwdata[7:0]);
         end
         if (paddr == PMC_ADDR_MASK) begin
            mask_reg <= pwdata[2:0];
         end
      end
   end

   // sticky events, write one to clear; a new event beats the clear
   always_comb begin
      status_next = status_reg;
      if (accessWrite && paddr == PMC_ADDR_STAT) begin
         status_next = status_reg & ~pwdata[2:0];
      end
      status_next[PMC_ST_WAKE]  = status_next[PMC_ST_WAKE]
                               || (state_reg == PMC_WAKE && state_next == PMC_RUN);
      status_next[PMC_ST_BOD]   = status_next[PMC_ST_BOD]
                               || (bodEvent && pwr_reg.brownoutIrqSelect);
      status_next[PMC_ST_FLASH] = status_next[PMC_ST_FLASH]
                               || (flashCmdReq && pwr_reg.brownoutPowerdown);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         status_reg <= PMC_ST_RESET;
         irq        <= 1'b0;
      end else begin
         status_reg <= status_next;
         irq        <= |(status_next & mask_reg);
      end
   end

   // power switches follow the next state so they line up with state_reg
   assign lowPowerNext = (state_next == PMC_PDOWN) || (state_next == PMC_TOTAL);
   assign rcKeep       = cfg_reg.rcIsSysClk && cfg_reg.rtcEnable;

   always_ff @(posedge mclk) begin
      if (rst) begin
         cpuHalt          <= 1'b0;
         oscEnable        <= 1'b1;
         rcOscEnable      <= 1'b1;
         xtalOscEnable    <= 1'b1;
         brownoutEnable   <= 1'b0;
         comparatorEnable <= 1'b0;
      end else begin
         cpuHalt          <= state_next != PMC_RUN;
         oscEnable        <= !lowPowerNext;
         rcOscEnable      <= !lowPowerNext || rcKeep;
         xtalOscEnable    <= !lowPowerNext
                          || (rtcActive && cfg_reg.rtcUsesXtal);
         brownoutEnable   <= !pwr_reg.brownoutPowerdown
                          && state_next != PMC_TOTAL;
         comparatorEnable <= cfg_reg.compEnable && state_next != PMC_TOTAL;
      end
   end

   // brownout reset as a one-cycle pulse; flash command gate follows each cycle of the request
   always_ff @(posedge mclk) begin
      if (rst) begin
         brownoutReset <= 1'b0;
         flashCmdGo    <= 1'b0;
         flashCmdAbort <= 1'b0;
      end else begin
         brownoutReset <= bodResetReq;
         flashCmdGo    <= flashCmdReq && !pwr_reg.brownoutPowerdown;
         flashCmdAbort <= flashCmdReq && pwr_reg.brownoutPowerdown;
      end
   end

   // baud tick: halving drops every other overflow, so duty stays one cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         halfBaud_reg <= 1'b0;
         uartBaudTick <= 1'b0;
      end else begin
         if (timer1Overflow) begin
            halfBaud_reg <= !halfBaud_reg;
         end
         uartBaudTick <= timer1Overflow
                      && (pwr_reg.baudDouble || halfBaud_reg);
      end
   end

   // serial control bit 7 is either the mode bit or the framing error
   always_ff @(posedge mclk) begin
      if (rst) begin
         serialBit7View       <= 1'b0;
         serialBit7IsFrameErr <= 1'b0;
      end else begin
         serialBit7View       <= pwr_reg.frameErrorViewSel ? uartFramingError
                                                           : uartModeBit;
         serialBit7IsFrameErr <= pwr_reg.frameErrorViewSel;
      end
   end

   // apb slave: zero wait, data captured in setup so it is a flop in access
   always_ff @(posedge mclk) begin
      if (rst) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (setupPhase) begin
            pslverr <= !hit;
            prdata  <= 32'h0000_0000;
            if (!pwrite) begin
               unique case (paddr)
                  PMC_ADDR_PWR:   prdata <= {24'h00_0000, pwr_reg};
                  PMC_ADDR_CFG:   prdata <= {22'h00_0000, cfg_reg};
                  PMC_ADDR_WEN:   prdata <= {24'h00_0000, wen_reg};
                  PMC_ADDR_STAT:  prdata <= {29'h0000_0000, status_reg};
                  PMC_ADDR_MASK:  prdata <= {29'h0000_0000, mask_reg};
                  PMC_ADDR_STATE: prdata <= {16'h0000, count_reg, state_reg};
                  default:        prdata <= 32'h0000_0000;
               endcase
            end
         end
      end
   end

   // checks beside the logic
   a_total_analog_off: assert property (@(posedge mclk) disable iff (rst)
      (state_reg == PMC_TOTAL) |-> (!brownoutEnable && !comparatorEnable))
      else $error("analog blocks powered in total power-down");

   a_total_no_bod: assert property (@(posedge mclk) disable iff (rst)
      (state_reg == PMC_TOTAL) |=> (!brownoutReset && !$rose(status_reg[PMC_ST_BOD])))
      else $error("brownout acted in total power-down");

   a_total_holds: assert property (@(posedge mclk) disable iff (rst)
      (state_reg == PMC_TOTAL && !commonWake) |=> (state_reg == PMC_TOTAL && cpuHalt))
      else $error("left total power-down without a permitted wake");

   a_rc_stopped: assert property (@(posedge mclk) disable iff (rst)
      ((state_reg == PMC_PDOWN || state_reg == PMC_TOTAL) && !rcKeep) |-> !rcOscEnable)
      else $error("rc oscillator running in power-down");

   a_total_entry: assert property (@(posedge mclk) disable iff (rst)
      (state_reg == PMC_RUN && pwrWrite && pwrWdata[1:0] == PMC_MODE_TOTAL)
      |=> (state_reg == PMC_TOTAL) ##1 !brownoutEnable)
      else $error("total power-down not entered");

   a_wake_length: assert property (@(posedge mclk) disable iff (rst)
      $rose(state_reg == PMC_WAKE) |-> (state_reg == PMC_WAKE)[*8]
      ##0 (count_reg == $past(count_reg) - 11'h001))
      else $error("oscillator start-up count cut short");

   a_wake_done: assert property (@(posedge mclk) disable iff (rst)
      (state_reg == PMC_WAKE && count_reg == 11'h000) |=> (state_reg == PMC_RUN && !cpuHalt))
      else $error("start-up count end did not resume");

   a_flash_abort: assert property (@(posedge mclk) disable iff (rst)
      (flashCmdReq && pwr_reg.brownoutPowerdown) |=> (flashCmdAbort && !flashCmdGo
      && status_reg[PMC_ST_FLASH]))
      else $error("flash command not aborted");

   a_baud_rate: assert property (@(posedge mclk) disable iff (rst)
      (timer1Overflow && !pwr_reg.baudDouble && !halfBaud_reg) |=> !uartBaudTick)
      else $error("halved baud tick passed an overflow");

   a_bod_select: assert property (@(posedge mclk) disable iff (rst)
      (bodEvent && pwr_reg.brownoutIrqSelect) |=> (!brownoutReset && status_reg[PMC_ST_BOD]))
      else $error("brownout interrupt mode issued a reset");

   a_serial_view: assert property (@(posedge mclk) disable iff (rst)
      ##1 serialBit7View == ($past(pwr_reg.frameErrorViewSel) ? $past(uartFramingError)
                                                             : $past(uartModeBit)))
      else $error("serial bit 7 view wrong");

endmodule

//--- core/pmc_pkg.sv
// package for the power mode controller: map, field layouts, timing, states
package pmc_pkg;
   // printed register offsets are indexes; byte address is index times four
   localparam logic [9:0]  PMC_IDX_PWR   = 10'h087;
   localparam logic [9:0]  PMC_IDX_CFG   = 10'h088;
   localparam logic [9:0]  PMC_IDX_WEN   = 10'h089;
   localparam logic [9:0]  PMC_IDX_STAT  = 10'h08a;
   localparam logic [9:0]  PMC_IDX_MASK  = 10'h08b;
   localparam logic [9:0]  PMC_IDX_STATE = 10'h08c;
   localparam logic [11:0] PMC_ADDR_PWR   = {PMC_IDX_PWR, 2'b00};
   localparam logic [11:0] PMC_ADDR_CFG   = {PMC_IDX_CFG, 2'b00};
   localparam logic [11:0] PMC_ADDR_WEN   = {PMC_IDX_WEN, 2'b00};
   localparam logic [11:0] PMC_ADDR_STAT  = {PMC_IDX_STAT, 2'b00};
   localparam logic [11:0] PMC_ADDR_MASK  = {PMC_IDX_MASK, 2'b00};
   localparam logic [11:0] PMC_ADDR_STATE = {PMC_IDX_STATE, 2'b00};

   // power mode select encodings
   localparam logic [1:0] PMC_MODE_NORMAL = 2'h0;
   localparam logic [1:0] PMC_MODE_IDLE   = 2'h1;
   localparam logic [1:0] PMC_MODE_PDOWN  = 2'h2;
   localparam logic [1:0] PMC_MODE_TOTAL  = 2'h3;

   // power control register, bit 7 first
   typedef struct packed {
      logic       baudDouble;
      logic       frameErrorViewSel;
      logic       brownoutPowerdown;
      logic       brownoutIrqSelect;
      logic       userFlagOne;
      logic       userFlagZero;
      logic [1:0] powerModeSel;
   } pmc_power_t;
   localparam logic [7:0] PMC_PWR_RESET = 8'h00;

   // system configuration register, bit 9 first
   typedef struct packed {
      logic compEnable;
      logic wdtResetEnable;
      logic extIrqOneLevel;
      logic extIrqZeroLevel;
      logic xtalClock;
      logic rcIsSysClk;
      logic rtcUsesXtal;
      logic rtcEnable;
      logic rtcPowerdown;
      logic watchdogClockSelect;
   } pmc_cfg_t;
   localparam logic [9:0] PMC_CFG_RESET = 10'h000;

   // interrupt enables used for wake-up, bit 7 first
   typedef struct packed {
      logic globalIrqEnable;
      logic bodEn;
      logic compEn;
      logic wdtEn;
      logic rtcEn;
      logic keypadEn;
      logic extOneEn;
      logic extZeroEn;
   } pmc_wen_t;
   localparam logic [7:0] PMC_WEN_RESET = 8'h00;

   // sticky event bits
   localparam int         PMC_ST_WAKE   = 0;
   localparam int         PMC_ST_BOD    = 1;
   localparam int         PMC_ST_FLASH  = 2;
   localparam logic [2:0] PMC_ST_RESET  = 3'h0;

   // oscillator start-up counts in clocks
   localparam logic [10:0] PMC_XTAL_STARTUP = 11'h400;
   localparam logic [10:0] PMC_RC_STARTUP   = 11'h100;

   typedef enum logic [4:0] {
      PMC_RUN   = 5'h01,
      PMC_IDLE  = 5'h02,
      PMC_PDOWN = 5'h04,
      PMC_TOTAL = 5'h08,
      PMC_WAKE  = 5'h10
   } pmc_state_t;
endpackage

//--- bench/tb_top.sv
// self-checking bench for the power mode controller
`timescale 1ns/100ps
module tb_top;
   import pmc_pkg::*;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, cpuHalt, oscEnable, rcOscEnable, xtalOscEnable;
   logic        brownoutEnable, comparatorEnable, brownoutReset, flashCmdGo, flashCmdAbort;
   logic        uartBaudTick, serialBit7View, serialBit7IsFrameErr, irq;
   logic        timer1Overflow = 1'b0;
   logic        flashCmdReq = 1'b0;
   logic        uartModeBit = 1'b0;
   logic        uartFramingError = 1'b0;
   logic [7:0]  ev = 8'h00;
   logic [31:0] rd;
   logic        er;
   logic [15:0] seed = 16'hc974;
   logic [7:0]  d;
   int          miscompares = 0;
   int          nChecks = 0;
   int          cyc, b0, t0, nBor = 0, nTick = 0, nGo = 0, nAbort = 0;

   pmc_power_mode_control uut (
      .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .brownoutPin(ev[6]), .extIrqZeroPin(ev[5]), .extIrqOnePin(ev[7]), .keypadIrq(ev[0]),
      .comparatorIrq(ev[1]), .rtcIrq(ev[2]), .wdtIrq(ev[3]), .wdtReset(ev[4]),
      .timer1Overflow(timer1Overflow), .flashCmdReq(flashCmdReq), .uartModeBit(uartModeBit),
      .uartFramingError(uartFramingError), .cpuHalt(cpuHalt), .oscEnable(oscEnable),
      .rcOscEnable(rcOscEnable), .xtalOscEnable(xtalOscEnable),
      .brownoutEnable(brownoutEnable), .comparatorEnable(comparatorEnable),
      .brownoutReset(brownoutReset), .flashCmdGo(flashCmdGo), .flashCmdAbort(flashCmdAbort),
      .uartBaudTick(uartBaudTick), .serialBit7View(serialBit7View),
      .serialBit7IsFrameErr(serialBit7IsFrameErr), .irq(irq));

   // 40 MHz clock
   initial begin
      forever #12.5 mclk = ~mclk;
   end

   // pulse counters, so short pulses are never missed by the sequence
   always @(posedge mclk) begin
      if (brownoutReset === 1'b1) nBor++;
      if (uartBaudTick === 1'b1) nTick++;
      if (flashCmdGo === 1'b1) nGo++;
      if (flashCmdAbort === 1'b1) nAbort++;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task print_verdict;
      if (miscompares == 0 && nChecks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task chk1(input logic a, input logic e, input string m);
      nChecks++;
      if (a !== e) begin
         miscompares++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask

   task chkw(input logic [31:0] a, input logic [31:0] e, input string m);
      nChecks++;
      if (a !== e) begin
         miscompares++;
         $display("mismatch at %0t: %s got %h", $time, m, a);
      end
   endtask

   task chkn(input int a, input int lo, input int hi, input string m);
      nChecks++;
      if (a < lo || a > hi) begin
         miscompares++;
         $display("mismatch at %0t: %s count %0d", $time, m, a);
      end
   endtask

   // one apb transfer; request held until pready is seen high
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   // counts edges until the processor runs again, capped past the longest wake
   task wait_run;
      cyc = 0;
      #1;
      while (cpuHalt !== 1'b0 && cyc < 1100) begin
         @(posedge mclk);
         #1;
         cyc++;
      end
      @(posedge mclk);
   endtask

   task bod_pulse;
      ev <= 8'h40;
      repeat (8) @(posedge mclk);
      ev <= 8'h00;
      wait_run;
   endtask

   // enter mode m, raise events e, expect a wake (wk) or none
   task run_case(input logic [1:0] m, input logic [9:0] c, input logic [7:0] w,
                 input logic [7:0] e, input bit wk);
      int lo;
      lo = (m == PMC_MODE_IDLE) ? 1 : (c[5] ? 1024 : 256);
      // synchronised pins reach the sequencer two cycles later
      lo = lo + ((e[5] | e[6] | e[7]) ? 3 : 0);
      apb(1'b1, PMC_ADDR_CFG, {22'h0, c});
      apb(1'b1, PMC_ADDR_WEN, {24'h0, w});
      apb(1'b1, PMC_ADDR_PWR, {30'h0, m});
      #1;
      chk1(cpuHalt, 1'b1, "not halted");
      if (m[1]) begin
         chk1(oscEnable, 1'b0, "osc");
         chk1(rcOscEnable, c[4] & c[2], "rc osc");
         chk1(xtalOscEnable, c[2] & ~c[1] & c[3], "xtal osc");
         chk1(brownoutEnable, m != PMC_MODE_TOTAL, "bod enable");
         chk1(comparatorEnable, c[9] & (m != PMC_MODE_TOTAL), "comp enable");
      end
      @(posedge mclk);
      ev <= e;
      wait_run;
      if (wk) chkn(cyc, lo, lo + 5, "wake time");
      else begin
         chkn(cyc, 1100, 1100, "wrong wake");
         ev <= e | 8'h01;
         apb(1'b1, PMC_ADDR_WEN, 32'h84);
         wait_run;
      end
      ev <= 8'h00;
      apb(1'b0, PMC_ADDR_STAT, 32'h0);
      chk1(rd[0], m[1], "wake flag");
      apb(1'b1, PMC_ADDR_STAT, 32'h7);
      apb(1'b0, PMC_ADDR_PWR, 32'h0);
      chkw(rd, 32'h0, "mode kept");
   endtask

   // watchdog against a hung handshake or wake
   initial begin
      repeat (60000) @(posedge mclk);
      miscompares++;
      print_verdict;
   end

   initial begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, PMC_ADDR_PWR + 12'(4 * i), 32'h0);
         chkw(rd, (i == 5) ? 32'h1 : 32'h0, "reset value");
      end
      apb(1'b0, 12'h000, 32'h0);
      chk1(er, 1'b1, "unmapped");
      chkw(rd, 32'h0, "unmapped data");
      // random flags and serial options with the mode left at normal
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         d = {seed[7:2], 2'b00};
         uartModeBit <= seed[8];
         uartFramingError <= seed[9];
         apb(1'b1, PMC_ADDR_PWR, {24'h0, d});
         apb(1'b0, PMC_ADDR_PWR, 32'h0);
         chkw(rd, {24'h0, d}, "flags");
         #1;
         chk1(serialBit7IsFrameErr, d[6], "view select");
         chk1(serialBit7View, d[6] ? seed[9] : seed[8], "serial bit 7");
         chk1(brownoutEnable, ~d[5], "bod enable");
         @(posedge mclk);
      end
      // baud halving and flash abort, both settings
      for (int b = 0; b < 2; b++) begin
         apb(1'b1, PMC_ADDR_PWR, {24'h0, b[0], 1'b0, b[0], 5'h00});
         t0 = nTick;
         b0 = nAbort;
         cyc = nGo;
         for (int k = 0; k < 4; k++) begin
            timer1Overflow <= 1'b1;
            flashCmdReq <= (k == 0);
            @(posedge mclk);
            timer1Overflow <= 1'b0;
            flashCmdReq <= 1'b0;
            @(posedge mclk);
         end
         repeat (2) @(posedge mclk);
         #1;
         chkn(nTick - t0, b ? 4 : 2, b ? 4 : 2, "baud ticks");
         chkn(nAbort - b0, b, b, "flash abort");
         chkn(nGo - cyc, 1 - b, 1 - b, "flash go");
         @(posedge mclk);
      end
      // brownout as reset, then powered down, then as masked interrupt
      apb(1'b1, PMC_ADDR_PWR, 32'h0);
      apb(1'b1, PMC_ADDR_WEN, 32'hc0);
      b0 = nBor;
      bod_pulse;
      chkn(nBor - b0, 1, 1, "bod reset");
      apb(1'b1, PMC_ADDR_PWR, 32'h20);
      bod_pulse;
      apb(1'b1, PMC_ADDR_PWR, 32'h10);
      bod_pulse;
      chkn(nBor - b0, 1, 1, "bod reset");
      apb(1'b0, PMC_ADDR_STAT, 32'h0);
      chkw(rd, 32'h6, "status");
      chk1(irq, 1'b0, "irq masked");
      apb(1'b1, PMC_ADDR_MASK, 32'h2);
      #1;
      chk1(irq, 1'b1, "irq unmasked");
      @(posedge mclk);
      apb(1'b1, PMC_ADDR_STAT, 32'h6);
      #1;
      chk1(irq, 1'b0, "irq cleared");
      @(posedge mclk);
      apb(1'b1, PMC_ADDR_PWR, 32'h0);
      b0 = nBor;
      run_case(PMC_MODE_TOTAL, 10'h214, 8'h84, 8'h01, 1'b1);
      run_case(PMC_MODE_TOTAL, 10'h02c, 8'h84, 8'h01, 1'b1);
      run_case(PMC_MODE_TOTAL, 10'h000, 8'h04, 8'h01, 1'b0);
      run_case(PMC_MODE_TOTAL, 10'h200, 8'ha4, 8'h02, 1'b0);
      run_case(PMC_MODE_PDOWN, 10'h200, 8'ha4, 8'h02, 1'b1);
      run_case(PMC_MODE_TOTAL, 10'h000, 8'hc4, 8'h40, 1'b0);
      chkn(nBor - b0, 0, 0, "bod reset in total");
      run_case(PMC_MODE_TOTAL, 10'h000, 8'h94, 8'h08, 1'b0);
      run_case(PMC_MODE_TOTAL, 10'h001, 8'h94, 8'h08, 1'b1);
      run_case(PMC_MODE_TOTAL, 10'h101, 8'h04, 8'h10, 1'b1);
      run_case(PMC_MODE_TOTAL, 10'h000, 8'h85, 8'h20, 1'b0);
      run_case(PMC_MODE_TOTAL, 10'h040, 8'h85, 8'h20, 1'b1);
      run_case(PMC_MODE_TOTAL, 10'h000, 8'h86, 8'h80, 1'b0);
      run_case(PMC_MODE_TOTAL, 10'h080, 8'h86, 8'h80, 1'b1);
      run_case(PMC_MODE_TOTAL, 10'h004, 8'h8c, 8'h04, 1'b1);
      run_case(PMC_MODE_TOTAL, 10'h006, 8'h8c, 8'h04, 1'b0);
      // brownout in reset mode wakes plain power-down by its enabled reset
      run_case(PMC_MODE_PDOWN, 10'h000, 8'h84, 8'h40, 1'b1);
      chkn(nBor - b0, 1, 1, "bod reset wake");
      run_case(PMC_MODE_IDLE, 10'h000, 8'h84, 8'h01, 1'b1);
      print_verdict;
   end
endmodule
